// [logic/psl_cfg.svh]
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// widths and scale
`define PSL_PCT_W     8
`define PSL_SEL_W     7
`define PSL_ADDR_W    12
`define PSL_DATA_W    32
`define PSL_ZERO      8'h00
`define PSL_FULL      8'h64
`define PSL_N_OBJ     128
`define PSL_N_GATE    10
`define PSL_N_THR     4
`define PSL_N_DBN     4
`define PSL_N_SW      5
`define PSL_N_POT     3
`define PSL_N_FN      4

////////////////////////////////////////////////////////////////////////////////
// object numbers on the routing network
`define PSL_OBJ_OFF   7'h00
`define PSL_OBJ_SW1   7'h01
`define PSL_OBJ_POT1  7'h0B
`define PSL_OBJ_THR1  7'h0E
`define PSL_OBJ_DBN1  7'h12
`define PSL_OBJ_VSPD  7'h28
`define PSL_OBJ_GATE1 7'h29
`define PSL_OBJ_FWD   7'h5C
`define PSL_OBJ_REV   7'h5D
`define PSL_OBJ_SPD   7'h5E
`define PSL_OBJ_EREV  7'h62
`define PSL_OBJ_ON    7'h64
`define PSL_OBJ_BATT  7'h6B

////////////////////////////////////////////////////////////////////////////////
// register map (byte addresses)
`define PSL_REG_STATUS   12'h000
`define PSL_REG_GATE0    12'h004
`define PSL_REG_THR0     12'h030
`define PSL_REG_DBN0     12'h040
`define PSL_REG_FN0      12'h050
`define PSL_REG_PEEK_SEL 12'h060
`define PSL_REG_PEEK_VAL 12'h064
`define PSL_REG_STRIDE   12'h004

// field positions
`define PSL_F_SELA    0
`define PSL_F_SELB    8
`define PSL_F_MODE    16
`define PSL_F_INV     18
`define PSL_F_PARAM   8
`define PSL_F_ST_THR  10
`define PSL_F_ST_DBN  14
`define PSL_F_ST_FN   18

////////////////////////////////////////////////////////////////////////////////
// timing
`define PSL_EVAL_US   1000
`define PSL_CLK_MHZ   125

`endif

// [logic/psl_pkg.sv]
`include "psl_cfg.svh"

package psl_pkg;
  typedef logic [`PSL_PCT_W-1:0] psl_pct_t;
  typedef logic [`PSL_SEL_W-1:0] psl_sel_t;
  typedef enum logic [1:0] {PSL_G_AND, PSL_G_OR, PSL_G_XOR} psl_gmode_e;
endpackage

// [logic/psl_obj_if.sv]
`timescale 1ns/1ns
`include "psl_cfg.svh"

interface psl_obj_if;
  psl_pkg::psl_pct_t   in_a;
  psl_pkg::psl_pct_t   in_b;
  psl_pkg::psl_gmode_e mode;
  logic                inv;
  logic [7:0]          cfg;
  logic                tick;
  psl_pkg::psl_pct_t   res;

  modport host (output in_a, output in_b, output mode, output inv, output cfg, output tick, input res);
  modport obj  (input in_a, input in_b, input mode, input inv, input cfg, input tick, output res);
endinterface

// [logic/psl_gate.sv]
`timescale 1ns/1ns
`include "psl_cfg.svh"

module psl_gate (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // object link
  psl_obj_if.obj   io
);
  import psl_pkg::*;

  psl_pct_t raw;
  psl_pct_t nxt_res;
  psl_pct_t res_ff;
  logic     a_on;
  logic     b_on;

  always_comb begin
    a_on = (io.in_a != `PSL_ZERO);
    b_on = (io.in_b != `PSL_ZERO);
    case (io.mode)
      PSL_G_AND: raw = (io.in_a < io.in_b) ? io.in_a : io.in_b; // R3
      PSL_G_OR:  raw = (io.in_a > io.in_b) ? io.in_a : io.in_b; // R4
      PSL_G_XOR: raw = (a_on ^ b_on) ? `PSL_FULL : `PSL_ZERO;   // R5
      default:   raw = (io.in_a < io.in_b) ? io.in_a : io.in_b;
    endcase
    // inputs are clamped upstream, so the difference never wraps
    nxt_res = io.inv ? (`PSL_FULL - raw) : raw; // R2
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      res_ff <= `PSL_ZERO;
    end else if (io.tick) begin
      res_ff <= nxt_res; // R14
    end
  end

  assign io.res = res_ff;
endmodule // psl_gate

// [logic/psl_dbnc.sv]
`timescale 1ns/1ns
`include "psl_cfg.svh"

module psl_dbnc (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // object link
  psl_obj_if.obj   io
);
  import psl_pkg::*;

  logic       in_on;
  logic       state_ff;
  logic [7:0] cnt_ff;

  assign in_on = (io.in_a != `PSL_ZERO); // R13

  // a change must persist cfg evaluation ticks; cfg of 0 or 1 passes at once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= 1'b0;
      cnt_ff   <= 8'h00;
    end else if (io.tick) begin
      if (in_on == state_ff) begin
        cnt_ff <= 8'h00;
      end else if (({1'b0, cnt_ff} + 9'h001) >= {1'b0, io.cfg}) begin
        state_ff <= in_on; // R8
        cnt_ff   <= 8'h00;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign io.res = state_ff ? `PSL_FULL : `PSL_ZERO; // R12
endmodule // psl_dbnc

// [logic/psl_top.sv]
// What this block does
// R1 - Ten logic gate objects numbered 41 to 50 each combine two inputs as AND, OR or XOR.
// R2 - Each gate has an option that inverts its result, giving NAND, NOR and XNOR.
// R3 - In AND mode a gate outputs the lower of its two input percentages.
// R4 - In OR mode a gate outputs the higher of its two input percentages.
// R5 - In XOR mode a gate is on when exactly one input is on and off otherwise.
// R6 - Every consumer takes its value from the object whose number is written into its select field.
// R7 - Threshold objects turn an analog percentage into an on or off value.
// R8 - Debounce objects filter a digital signal before it is routed to a consumer.
// R9 - A threshold drives 100% when its input is above its setpoint and 0% otherwise.
// R10 - The battery charge level is a routable source at object number 107.
// R11 - The speed mode consumer accepts a gate as source when its select holds the gate number.
// R12 - Digital objects carry 0% or 100%; analog objects carry any value from 0% to 100%.
// R13 - Where a digital value is expected, 0% is off and any non-zero value is on.
// R14 - All objects are re-evaluated once per evaluation tick from registered values.
// R15 - Percent values are unsigned with 100% as full scale; inversion yields 100% minus the value.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "psl_cfg.svh"

module psl_top #(
  parameter int unsigned EVAL_CYC = `PSL_EVAL_US * `PSL_CLK_MHZ
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // apb slave
  input  wire logic [`PSL_ADDR_W-1:0]  paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`PSL_DATA_W-1:0]  pwdata,
  output logic      [`PSL_DATA_W-1:0]  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // source pins
  input  wire logic [`PSL_N_SW-1:0]    switch_in,
  input  wire psl_pkg::psl_pct_t       pot_in [`PSL_N_POT],
  input  wire psl_pkg::psl_pct_t       vehicle_speed,
  input  wire psl_pkg::psl_pct_t       battery_charge_level,
  // consumer functions
  output psl_pkg::psl_pct_t            fwd_pct,
  output psl_pkg::psl_pct_t            rev_pct,
  output psl_pkg::psl_pct_t            spd_mode_pct,
  output psl_pkg::psl_pct_t            erev_pct
);
  import psl_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [31:0]             eval_cnt_ff;
  logic                    tick_ff;
  logic [`PSL_N_SW-1:0]    sw_meta_ff;
  logic [`PSL_N_SW-1:0]    sw_sync_ff;
  psl_pct_t                pot_meta_ff [`PSL_N_POT];
  psl_pct_t                pot_sync_ff [`PSL_N_POT];
  psl_pct_t                vspd_meta_ff;
  psl_pct_t                vspd_sync_ff;
  psl_pct_t                batt_meta_ff;
  psl_pct_t                batt_sync_ff;
  psl_sel_t                gate_sa_ff  [`PSL_N_GATE];
  psl_sel_t                gate_sb_ff  [`PSL_N_GATE];
  logic [1:0]              gate_md_ff  [`PSL_N_GATE];
  logic                    gate_inv_ff [`PSL_N_GATE];
  psl_sel_t                thr_sel_ff  [`PSL_N_THR];
  psl_pct_t                thr_set_ff  [`PSL_N_THR];
  psl_sel_t                dbn_sel_ff  [`PSL_N_DBN];
  logic [7:0]              dbn_time_ff [`PSL_N_DBN];
  psl_sel_t                fn_sel_ff   [`PSL_N_FN];
  psl_sel_t                peek_sel_ff;
  psl_pct_t                thr_ff      [`PSL_N_THR];
  psl_pct_t                fn_ff       [`PSL_N_FN];
  psl_pct_t                gate_res    [`PSL_N_GATE];
  psl_pct_t                dbn_res     [`PSL_N_DBN];
  psl_pct_t                obj         [`PSL_N_OBJ];
  logic [`PSL_DATA_W-1:0]  prdata_ff;
  logic                    pready_ff;
  logic                    pslverr_ff;
  logic [`PSL_DATA_W-1:0]  rd_data;
  logic                    rd_hit;
  logic                    wr_en;
  function automatic psl_pct_t clamp(input psl_pct_t v);
    clamp = (v > `PSL_FULL) ? `PSL_FULL : v; // R12 R15
  endfunction
  function automatic psl_pct_t to_dig(input logic on);
    to_dig = on ? `PSL_FULL : `PSL_ZERO; // R12
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // evaluation tick
  // one tick per evaluation period keeps every consumer on the same snapshot
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eval_cnt_ff <= 32'h0;
      tick_ff     <= 1'b0;
    end else if (eval_cnt_ff >= EVAL_CYC - 32'h1) begin
      eval_cnt_ff <= 32'h0;
      tick_ff     <= 1'b1; // R14
    end else begin
      eval_cnt_ff <= eval_cnt_ff + 32'h1;
      tick_ff     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // analog words are expected to move slowly; a torn sample lasts one clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sw_meta_ff   <= '0;
      sw_sync_ff   <= '0;
      vspd_meta_ff <= `PSL_ZERO;
      vspd_sync_ff <= `PSL_ZERO;
      batt_meta_ff <= `PSL_ZERO;
      batt_sync_ff <= `PSL_ZERO;
      pot_meta_ff  <= '{default: `PSL_ZERO};
      pot_sync_ff  <= '{default: `PSL_ZERO};
    end else begin
      sw_meta_ff   <= switch_in;
      sw_sync_ff   <= sw_meta_ff;
      vspd_meta_ff <= vehicle_speed;
      vspd_sync_ff <= vspd_meta_ff;
      batt_meta_ff <= battery_charge_level;
      batt_sync_ff <= batt_meta_ff;
      for (int i = 0; i < `PSL_N_POT; i++) begin
        pot_meta_ff[i] <= pot_in[i];
        pot_sync_ff[i] <= pot_meta_ff[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // object network
  always_comb begin
    for (int i = 0; i < `PSL_N_OBJ; i++) begin
      obj[i] = `PSL_ZERO;
    end
    obj[`PSL_OBJ_ON] = `PSL_FULL;
    for (int i = 0; i < `PSL_N_SW; i++) begin
      obj[`PSL_OBJ_SW1 + i] = to_dig(sw_sync_ff[i]);
    end
    for (int i = 0; i < `PSL_N_POT; i++) begin
      obj[`PSL_OBJ_POT1 + i] = clamp(pot_sync_ff[i]);
    end
    for (int i = 0; i < `PSL_N_THR; i++) begin
      obj[`PSL_OBJ_THR1 + i] = thr_ff[i];
      obj[`PSL_OBJ_DBN1 + i] = dbn_res[i];
    end
    for (int i = 0; i < `PSL_N_GATE; i++) begin
      obj[`PSL_OBJ_GATE1 + i] = gate_res[i]; // R1
    end
    obj[`PSL_OBJ_VSPD] = clamp(vspd_sync_ff);
    obj[`PSL_OBJ_BATT] = clamp(batt_sync_ff); // R10
    obj[`PSL_OBJ_FWD]  = fn_ff[0];
    obj[`PSL_OBJ_REV]  = fn_ff[1];
    obj[`PSL_OBJ_SPD]  = fn_ff[2];
    obj[`PSL_OBJ_EREV] = fn_ff[3];
  end

  //////////////////////////////////////////////////////////////////////////////
  // gates and debouncers
  for (genvar g = 0; g < `PSL_N_GATE; g++) begin : g_gate
    psl_obj_if gif ();
    assign gif.in_a = obj[gate_sa_ff[g]]; // R6
    assign gif.in_b = obj[gate_sb_ff[g]];
    assign gif.mode = psl_gmode_e'(gate_md_ff[g]);
    assign gif.inv  = gate_inv_ff[g];
    assign gif.cfg  = 8'h00;
    assign gif.tick = tick_ff;
    assign gate_res[g] = gif.res;
    psl_gate u_gate (
      .clk  (clk),
      .nrst (nrst),
      .io   (gif)
    );
  end

  for (genvar d = 0; d < `PSL_N_DBN; d++) begin : g_dbn
    psl_obj_if dif ();
    assign dif.in_a = obj[dbn_sel_ff[d]]; // R6
    assign dif.in_b = `PSL_ZERO;
    assign dif.mode = PSL_G_AND;
    assign dif.inv  = 1'b0;
    assign dif.cfg  = dbn_time_ff[d];
    assign dif.tick = tick_ff;
    assign dbn_res[d] = dif.res;
    psl_dbnc u_dbnc (
      .clk  (clk),
      .nrst (nrst),
      .io   (dif)
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // thresholds
  // an input equal to the setpoint reads as off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      thr_ff <= '{default: `PSL_ZERO};
    end else if (tick_ff) begin
      for (int i = 0; i < `PSL_N_THR; i++) begin
        thr_ff[i] <= to_dig(obj[thr_sel_ff[i]] > thr_set_ff[i]); // R7 R9
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // consumer functions
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fn_ff <= '{default: `PSL_ZERO};
    end else if (tick_ff) begin
      for (int i = 0; i < `PSL_N_FN; i++) begin
        fn_ff[i] <= obj[fn_sel_ff[i]]; // R6 R11 R14
      end
    end
  end

  assign fwd_pct      = fn_ff[0];
  assign rev_pct      = fn_ff[1];
  assign spd_mode_pct = fn_ff[2];
  assign erev_pct     = fn_ff[3];

  //////////////////////////////////////////////////////////////////////////////
  // apb read decode
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b0;
    if (paddr == `PSL_REG_STATUS) begin
      rd_hit = 1'b1;
      for (int i = 0; i < `PSL_N_GATE; i++) begin
        rd_data[i] = (gate_res[i] != `PSL_ZERO); // R13
      end
      for (int i = 0; i < `PSL_N_THR; i++) begin
        rd_data[`PSL_F_ST_THR + i] = (thr_ff[i] != `PSL_ZERO);
        rd_data[`PSL_F_ST_DBN + i] = (dbn_res[i] != `PSL_ZERO);
        rd_data[`PSL_F_ST_FN + i]  = (fn_ff[i] != `PSL_ZERO);
      end
    end
    for (int i = 0; i < `PSL_N_GATE; i++) begin
      if (paddr == `PSL_ADDR_W'(`PSL_REG_GATE0 + `PSL_REG_STRIDE * i)) begin
        rd_hit = 1'b1;
        rd_data[`PSL_F_SELA +: `PSL_SEL_W] = gate_sa_ff[i];
        rd_data[`PSL_F_SELB +: `PSL_SEL_W] = gate_sb_ff[i];
        rd_data[`PSL_F_MODE +: 2]          = gate_md_ff[i];
        rd_data[`PSL_F_INV]                = gate_inv_ff[i];
      end
    end
    for (int i = 0; i < `PSL_N_THR; i++) begin
      if (paddr == `PSL_ADDR_W'(`PSL_REG_THR0 + `PSL_REG_STRIDE * i)) begin
        rd_hit = 1'b1;
        rd_data[`PSL_F_SELA +: `PSL_SEL_W]  = thr_sel_ff[i];
        rd_data[`PSL_F_PARAM +: `PSL_PCT_W] = thr_set_ff[i];
      end
      if (paddr == `PSL_ADDR_W'(`PSL_REG_DBN0 + `PSL_REG_STRIDE * i)) begin
        rd_hit = 1'b1;
        rd_data[`PSL_F_SELA +: `PSL_SEL_W]  = dbn_sel_ff[i];
        rd_data[`PSL_F_PARAM +: `PSL_PCT_W] = dbn_time_ff[i];
      end
      if (paddr == `PSL_ADDR_W'(`PSL_REG_FN0 + `PSL_REG_STRIDE * i)) begin
        rd_hit = 1'b1;
        rd_data[`PSL_F_SELA +: `PSL_SEL_W] = fn_sel_ff[i];
      end
    end
    if (paddr == `PSL_REG_PEEK_SEL) begin
      rd_hit = 1'b1;
      rd_data[`PSL_F_SELA +: `PSL_SEL_W] = peek_sel_ff;
    end
    if (paddr == `PSL_REG_PEEK_VAL) begin
      rd_hit = 1'b1;
      rd_data[`PSL_F_SELA +: `PSL_PCT_W] = obj[peek_sel_ff];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake
  // answer captured in the setup cycle, so every access has exactly one wait-free phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata_ff  <= '0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~rd_hit;
      prdata_ff  <= (psel & ~penable & ~pwrite) ? rd_data : '0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign wr_en   = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      peek_sel_ff <= `PSL_OBJ_OFF;
      for (int i = 0; i < `PSL_N_GATE; i++) begin
        gate_sa_ff[i]  <= `PSL_OBJ_OFF;
        gate_sb_ff[i]  <= `PSL_OBJ_OFF;
        gate_md_ff[i]  <= 2'h0;
        gate_inv_ff[i] <= 1'b0;
      end
      for (int i = 0; i < `PSL_N_THR; i++) begin
        thr_sel_ff[i]  <= `PSL_OBJ_OFF;
        thr_set_ff[i]  <= `PSL_ZERO;
        dbn_sel_ff[i]  <= `PSL_OBJ_OFF;
        dbn_time_ff[i] <= 8'h00;
        fn_sel_ff[i]   <= `PSL_OBJ_OFF;
      end
    end else if (wr_en) begin
      for (int i = 0; i < `PSL_N_GATE; i++) begin
        if (paddr == `PSL_ADDR_W'(`PSL_REG_GATE0 + `PSL_REG_STRIDE * i)) begin
          gate_sa_ff[i]  <= pwdata[`PSL_F_SELA +: `PSL_SEL_W];
          gate_sb_ff[i]  <= pwdata[`PSL_F_SELB +: `PSL_SEL_W];
          gate_md_ff[i]  <= pwdata[`PSL_F_MODE +: 2];
          gate_inv_ff[i] <= pwdata[`PSL_F_INV]; // R2
        end
      end
      for (int i = 0; i < `PSL_N_THR; i++) begin
        if (paddr == `PSL_ADDR_W'(`PSL_REG_THR0 + `PSL_REG_STRIDE * i)) begin
          thr_sel_ff[i] <= pwdata[`PSL_F_SELA +: `PSL_SEL_W];
          thr_set_ff[i] <= pwdata[`PSL_F_PARAM +: `PSL_PCT_W];
        end
        if (paddr == `PSL_ADDR_W'(`PSL_REG_DBN0 + `PSL_REG_STRIDE * i)) begin
          dbn_sel_ff[i]  <= pwdata[`PSL_F_SELA +: `PSL_SEL_W];
          dbn_time_ff[i] <= pwdata[`PSL_F_PARAM +: `PSL_PCT_W];
        end
        if (paddr == `PSL_ADDR_W'(`PSL_REG_FN0 + `PSL_REG_STRIDE * i)) begin
          fn_sel_ff[i] <= pwdata[`PSL_F_SELA +: `PSL_SEL_W]; // R6
        end
      end
      if (paddr == `PSL_REG_PEEK_SEL) begin
        peek_sel_ff <= pwdata[`PSL_F_SELA +: `PSL_SEL_W];
      end
    end
  end
endmodule // psl_top

// [dv/psl_top_asserts.sv]
`timescale 1ns/1ns
`include "psl_cfg.svh"

module psl_top_asserts #(
  parameter int unsigned EVAL_CYC = 8
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // apb slave
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [`PSL_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // consumer functions
  input wire psl_pkg::psl_pct_t      fwd_pct,
  input wire psl_pkg::psl_pct_t      rev_pct,
  input wire psl_pkg::psl_pct_t      spd_mode_pct,
  input wire psl_pkg::psl_pct_t      erev_pct
);
  import psl_pkg::*;

  logic [31:0] outs;
  logic [31:0] prev_ff;
  logic [31:0] cnt_ff;

  assign outs = {fwd_pct, rev_pct, spd_mode_pct, erev_pct};

  // cycles since any consumer last moved
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_ff <= 32'h0;
      cnt_ff  <= 32'h0;
    end else begin
      prev_ff <= outs;
      cnt_ff  <= (outs != prev_ff) ? 32'h0 : cnt_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (@(posedge clk) disable iff (!nrst)
    psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_in_access: assert property (@(posedge clk) disable iff (!nrst)
    pready |-> psel && penable) else $error("ready outside access");
  a_ready_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    pready |=> !pready) else $error("ready held too long");
  a_error_no_data: assert property (@(posedge clk) disable iff (!nrst)
    pslverr |-> pready && prdata == 32'h0) else $error("error without ready or with data");
  a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!nrst)
    !pready |-> prdata == 32'h0) else $error("read data outside access");
  a_out_full_scale: assert property (@(posedge clk) disable iff (!nrst)
    fwd_pct <= 8'h64 && rev_pct <= 8'h64 && spd_mode_pct <= 8'h64 && erev_pct <= 8'h64)
    else $error("consumer above full scale");
  // no disable here: this one watches the reset itself
  a_reset_clears_all: assert property (@(posedge clk)
    !nrst |=> outs == 32'h0 && !pready && !pslverr) else $error("outputs not cleared by reset");
  // a per-clock update would show up as a short gap
  a_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
    outs != prev_ff |-> cnt_ff >= EVAL_CYC - 2) else $error("consumer moved between ticks");

endmodule // psl_top_asserts

// [dv/psl_top_test.sv]
`timescale 1ns/1ns
`include "psl_cfg.svh"

module psl_top_test;
  import psl_pkg::*;

  localparam int unsigned EVAL_CYC = 10;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] mode;
    logic       inv;
    logic [7:0] res;
  } psl_row_s;

  logic                   clk;
  logic                   nrst;
  logic [`PSL_ADDR_W-1:0] paddr;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [`PSL_DATA_W-1:0] pwdata;
  logic [`PSL_DATA_W-1:0] prdata;
  logic                   pready;
  logic                   pslverr;
  logic [`PSL_N_SW-1:0]   switch_in;
  psl_pct_t               pot_in [`PSL_N_POT];
  psl_pct_t               vehicle_speed;
  psl_pct_t               battery_charge_level;
  psl_pct_t               fwd_pct;
  psl_pct_t               rev_pct;
  psl_pct_t               spd_mode_pct;
  psl_pct_t               erev_pct;
  logic [31:0]            rd;
  logic [31:0]            w;
  logic                   err;
  int                     failures;
  int                     comparisons;
  int                     cycles;

  // pot1 feeds input a, pot2 input b; mode code 3 falls back to and
  psl_row_s rows [10] = '{
    '{8'h1E, 8'h46, PSL_G_AND, 1'b0, 8'h1E}, '{8'h1E, 8'h46, PSL_G_OR,  1'b0, 8'h46},
    '{8'h1E, 8'h00, PSL_G_XOR, 1'b0, 8'h64}, '{8'h1E, 8'h46, PSL_G_XOR, 1'b0, 8'h00},
    '{8'h00, 8'h00, PSL_G_XOR, 1'b0, 8'h00}, '{8'h64, 8'h64, PSL_G_AND, 1'b1, 8'h00},
    '{8'h00, 8'h64, PSL_G_OR,  1'b1, 8'h00}, '{8'h00, 8'h00, PSL_G_XOR, 1'b1, 8'h64},
    '{8'h1E, 8'h46, PSL_G_AND, 1'b1, 8'h46}, '{8'h32, 8'h50, 2'h3,      1'b0, 8'h32}};

  psl_top #(.EVAL_CYC(EVAL_CYC)) uut (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_in(switch_in),
    .pot_in(pot_in), .vehicle_speed(vehicle_speed), .battery_charge_level(battery_charge_level),
    .fwd_pct(fwd_pct), .rev_pct(rev_pct), .spd_mode_pct(spd_mode_pct), .erev_pct(erev_pct));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [11:0] addr, input logic wr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= addr;
    pwrite  <= wr;
    pwdata  <= data;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    check("pready", {31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n * EVAL_CYC) @(posedge clk);
  endtask

  function automatic logic [31:0] gate_word(input logic [6:0] sa, input logic [6:0] sb,
                                            input logic [1:0] m, input logic inv);
    return {13'h0, inv, m, 1'b0, sb, 1'b0, sa};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    switch_in = 5'h00;
    pot_in = '{default: 8'h00};
    vehicle_speed = 8'h00;
    battery_charge_level = 8'h00;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    check("fwd_reset", fwd_pct, 8'h00);
    apb(`PSL_REG_GATE0, 1'b0, 32'h0);
    check("gate0_reset", rd, 32'h0);
    $display("test reset done");

    for (int i = 0; i < 10; i++) begin
      w = gate_word(`PSL_OBJ_POT1, `PSL_OBJ_POT1 + 7'h01, rows[i].mode, rows[i].inv);
      pot_in[0] <= rows[i].a;
      pot_in[1] <= rows[i].b;
      apb(`PSL_REG_GATE0 + 12'(4 * i), 1'b1, w);
      apb(`PSL_REG_GATE0 + 12'(4 * i), 1'b0, 32'h0);
      check("gate_cfg", rd, w);
      apb(`PSL_REG_FN0, 1'b1, 32'(`PSL_OBJ_GATE1 + 7'(i)));
      ticks(4);
      check("gate_out", fwd_pct, rows[i].res);
    end
    $display("test gate table done");

    apb(`PSL_REG_FN0, 1'b1, 32'(`PSL_OBJ_SW1));
    apb(`PSL_REG_FN0 + 12'h004, 1'b1, 32'(`PSL_OBJ_SW1 + 7'h01));
    switch_in <= 5'h01;
    ticks(3);
    check("fwd_sw1", fwd_pct, 8'h64);
    check("rev_sw1", rev_pct, 8'h00);
    switch_in <= 5'h02;
    ticks(3);
    check("fwd_sw2", fwd_pct, 8'h00);
    check("rev_sw2", rev_pct, 8'h64);
    $display("test switch routing done");

    // third threshold watches battery at 20 percent, gate 1 ands it with switch 3
    apb(`PSL_REG_THR0 + 12'h008, 1'b1, {16'h0, 8'h14, 1'b0, `PSL_OBJ_BATT});
    apb(`PSL_REG_GATE0, 1'b1, gate_word(`PSL_OBJ_THR1 + 7'h02, 7'h03, PSL_G_AND, 1'b0));
    apb(`PSL_REG_FN0 + 12'h008, 1'b1, 32'(`PSL_OBJ_GATE1));
    switch_in <= 5'h04;
    for (int j = 0; j < 3; j++) begin
      battery_charge_level <= 8'h15 - 8'(j);
      ticks(5);
      check("spd_mode", spd_mode_pct, (j == 0) ? 8'h64 : 8'h00);
    end
    $display("test battery gating done");

    // a one-tick pulse must not survive a three-tick debounce
    pot_in[1] <= 8'h00;
    apb(`PSL_REG_THR0, 1'b1, {16'h0, 8'h32, 1'b0, `PSL_OBJ_POT1 + 7'h01});
    apb(`PSL_REG_DBN0, 1'b1, {16'h0, 8'h03, 1'b0, `PSL_OBJ_THR1});
    apb(`PSL_REG_FN0 + 12'h00C, 1'b1, 32'(`PSL_OBJ_DBN1));
    ticks(6);
    pot_in[1] <= 8'h33;
    ticks(1);
    pot_in[1] <= 8'h00;
    ticks(6);
    check("erev_glitch", erev_pct, 8'h00);
    pot_in[1] <= 8'h64;
    ticks(8);
    check("erev_held", erev_pct, 8'h64);
    apb(`PSL_REG_STATUS, 1'b0, 32'h0);
    check("status", rd, 32'h002047A2);
    $display("test debounce done");

    apb(`PSL_REG_PEEK_SEL, 1'b1, 32'(`PSL_OBJ_ON));
    apb(`PSL_REG_PEEK_SEL, 1'b0, 32'h0);
    check("peek_sel", rd, 32'(`PSL_OBJ_ON));
    apb(`PSL_REG_PEEK_VAL, 1'b1, 32'h55);
    apb(`PSL_REG_PEEK_VAL, 1'b0, 32'h0);
    check("peek_on", rd, 32'h64);
    pot_in[2] <= 8'hFF;
    apb(`PSL_REG_PEEK_SEL, 1'b1, 32'(`PSL_OBJ_POT1 + 7'h02));
    apb(`PSL_REG_PEEK_VAL, 1'b0, 32'h0);
    check("peek_clamp", rd, 32'h64);
    apb(12'h0FC, 1'b0, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    $display("test register access done");

    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check("erev_rerst", erev_pct, 8'h00);
    nrst <= 1'b1;
    apb(`PSL_REG_FN0 + 12'h00C, 1'b0, 32'h0);
    check("fn_rerst", rd, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end

endmodule // psl_top_test

bind psl_top psl_top_asserts #(.EVAL_CYC(EVAL_CYC)) u_asserts (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fwd_pct(fwd_pct), .rev_pct(rev_pct), .spd_mode_pct(spd_mode_pct),
  .erev_pct(erev_pct));
